/* File: core/swcrc_chip_select.sv */
/*
 * Two address-range chip selects from the top address nibble.
 * Assumes the boundary and enable bits come from the control registers.
 */
`timescale 1ns/1ps
module swcrc_chip_select (
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   input  wire logic [3:0] nibble,
   input  wire logic [7:0] bound,
   input  wire logic       en_low,
   input  wire logic       en_high,
   output logic            cs_low_n,
   output logic            cs_high_n
);
   logic hit_low;
   logic hit_high;

   // Address only, no strobe, see RL2
   assign hit_low  = nibble <= bound[3:0]; // see RL16
   assign hit_high = (nibble > bound[3:0]) && (nibble <= bound[7:4]);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cs_low_n  <= 1'b1;
         cs_high_n <= 1'b1;
      end else begin
         cs_low_n  <= ~(en_low & hit_low); // see RL17
         cs_high_n <= ~(en_high & hit_high);
      end
   end

   AST_CS_LOW: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RL16
      en_low && nibble <= bound[3:0] |=> !cs_low_n) else $error("low range select missing");
   AST_CS_HIGH: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RL16
      !(nibble > bound[3:0] && nibble <= bound[7:4]) |=> cs_high_n)
      else $error("high range select outside its range");
endmodule : swcrc_chip_select

/* File: core/swcrc_pkg.sv */
/*
 * Shared constants, carrier and state types of the system control block.
 * Assumes a 20 MHz system clock, one clock period per processor T state.
 */
package swcrc_pkg;

   // Indirect register port and register indexes
   localparam logic [7:0] PTR_PORT  = 8'hee;
   localparam logic [7:0] DATA_PORT = 8'hef;
   localparam logic [7:0] IDX_WAIT  = 8'h00;
   localparam logic [7:0] IDX_MEMB  = 8'h01;
   localparam logic [7:0] IDX_CSB   = 8'h02;
   localparam logic [7:0] IDX_MISC  = 8'h03;

   // Values after reset
   localparam logic [7:0] WAIT_RST  = 8'hff;
   localparam logic [7:0] MEMB_RST  = 8'hf0;
   localparam logic [7:0] CSB_RST   = 8'h0f;
   localparam logic [7:0] MISC_RST  = 8'h01;

   // Field positions
   localparam int WC_CHAIN_HI = 7;
   localparam int WC_CHAIN_LO = 6;
   localparam int WC_VECT     = 5;
   localparam int WC_OFE      = 4;
   localparam int WC_MEM_HI   = 3;
   localparam int WC_MEM_LO   = 2;
   localparam int WC_IO_HI    = 1;
   localparam int WC_IO_LO    = 0;
   localparam int MC_CS0_EN   = 0;
   localparam int MC_CS1_EN   = 1;
   localparam int MC_RST_DIS  = 2;

   // Opcodes of the return sequence
   localparam logic [7:0] OPC_PREFIX = 8'hed;
   localparam logic [7:0] OPC_RETURN_FROM_INTERRUPT   = 8'h4d;

   // Timing
   localparam int CLK_HZ          = 20_000_000;
   localparam int POR_TIME_MS     = 25;
   localparam int POR_CYCLES      = POR_TIME_MS * (CLK_HZ / 1000);
   localparam int EXT_RST_CYCLES  = 16;
   localparam int EXT_RST_MIN     = 3;
   localparam int BOOT_FETCHES    = 16;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  data;
      logic        fetch_cycle_strobe_n;
      logic        mem_request_n;
      logic        io_request_strobe_n;
      logic        rd_n;
      logic        wr_n;
   } swcrc_bus_t;

   typedef enum logic [1:0] {
      WS_IDLE   = 2'b00,
      WS_COUNT  = 2'b01,
      WS_SETTLE = 2'b10,
      WS_EXT    = 2'b11
   } swcrc_ws_t;

   // Two-bit field to 0, 2, 4 or 6 waits
   function automatic logic [2:0] pair_waits(input logic [1:0] f);
      pair_waits = {f, 1'b0};
   endfunction : pair_waits

   // On-chip peripheral port
   function automatic logic onchip_port(input logic [7:0] a);
      onchip_port = (a[7:2] == 6'h04) || (a[7:3] == 5'h03) ||
                    (a == 8'hf0) || (a == 8'hf1) || (a == 8'hf4) ||
                    (a == PTR_PORT) || (a == DATA_PORT);
   endfunction : onchip_port

endpackage : swcrc_pkg

/* File: core/swcrc_reset_stretch.sv */
/*
 * Reset pin stretcher: power-on hold and external reset extension.
 * Assumes sys_rst marks supply rising past its threshold and an
 * external pull-up on the reset pin.
 */
`timescale 1ns/1ps
module swcrc_reset_stretch #(
   parameter int POR_CYCLES = swcrc_pkg::POR_CYCLES,
   parameter int EXT_CYCLES = swcrc_pkg::EXT_RST_CYCLES
) (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic pin_n,
   input  wire logic out_disable,
   output logic      drive_oe,
   output logic      por_done
);
   localparam int PW = $clog2(POR_CYCLES + 1);
   localparam int EW = $clog2(EXT_CYCLES + 1);

   logic [PW-1:0] por_cnt_ff;
   logic [EW-1:0] ext_cnt_ff;
   logic          pin_d_ff;
   logic          drive_ff;
   logic          ext_start;

   assign ext_start = por_done & pin_d_ff & ~pin_n & ~drive_ff & ~out_disable;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         por_cnt_ff <= PW'(POR_CYCLES); // see RL3
      end else if (por_cnt_ff != '0) begin
         por_cnt_ff <= por_cnt_ff - 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ext_cnt_ff <= '0;
      end else if (ext_start) begin
         ext_cnt_ff <= EW'(EXT_CYCLES); // see RL5
      end else if (ext_cnt_ff != '0) begin
         ext_cnt_ff <= ext_cnt_ff - 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pin_d_ff <= 1'b1;
         drive_ff <= 1'b1;
         por_done <= 1'b0;
      end else begin
         pin_d_ff <= pin_n;
         por_done <= (por_cnt_ff <= PW'(1));
         // Released once both counts run out, see RL4
         drive_ff <= (por_cnt_ff > PW'(1)) | ext_start | (ext_cnt_ff > EW'(1));
      end
   end

   assign drive_oe = drive_ff;

   AST_POR_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RL3
      !por_done |-> drive_oe) else $error("reset pin released before power-on end");
   AST_POR_RELEASE: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RL4
      $rose(por_done) && ext_cnt_ff == '0 |-> !drive_oe) else $error("reset pin still driven");
   AST_EXT_PULSE: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RL5
      ext_start |=> drive_oe [*8] ##1 drive_oe [*8] ##1 !drive_oe)
      else $error("external reset not stretched 16 cycles");
endmodule : swcrc_reset_stretch

/* File: core/swcrc_top.sv */
/*
 * System control block: indirect control registers, wait state
 * generator, chip selects, reset pin control and daisy chain gating.
 * Assumes CPU strobes, address and data synchronous to ref_clk and
 * one clock per T state; the reset pin has an external pull-up.
 */
`timescale 1ns/1ps
// Behaviour
// RL1 - Chain output high only if chain input high and no on-chip interrupt served.
// RL2 - First chip select decoded from top address nibble only, no strobes.
// RL3 - At power-up hold reset pin low 25 to 75 ms via open drain.
// RL4 - After power-on interval stop driving the reset pin.
// RL5 - External reset fall with output enabled: drive pin low 16 cycles.
// RL6 - With reset output disabled, outside holds reset at least 3 cycles.
// RL7 - External wait sampled only after programmed waits, not in chain settle.
// RL8 - Memory cycles get 0 to 3 programmed wait states.
// RL9 - Memory waits only inside the programmed memory wait range.
// RL10 - Optional one extra wait on each opcode fetch.
// RL11 - External I/O cycles get 0, 2, 4 or 6 wait states.
// RL12 - No I/O waits for on-chip peripheral ports.
// RL13 - Vector wait option adds one wait after I/O strobe in acknowledge.
// RL14 - Acknowledge gets 0, 2, 4 or 6 settle waits before I/O strobe.
// RL15 - Chain wait 4 or 6: return sequence gets 2 or 4 waits, else 1.
// RL16 - Selects by nibble against low and high boundary fields.
// RL17 - Each select has enable; first enabled with boundary F at reset.
// RL18 - Control registers reached by index at pointer port then data port.
module swcrc_top #(
   parameter int POR_CYCLES = swcrc_pkg::POR_CYCLES
) (
   input  wire logic                 ref_clk,
   input  wire logic                 sys_rst,
   input  wire swcrc_pkg::swcrc_bus_t cpu_bus,
   input  wire logic                 ext_wait_n,
   input  wire logic                 onchip_irq_service,
   input  wire logic                 chain_priority_in,
   input  wire logic                 reset_pin_n_in,
   output logic                      reset_pin_out,
   output logic                      reset_pin_oe,
   output logic                      cpu_wait_n,
   output logic [7:0]                data_out,
   output logic                      data_oe,
   output logic                      chip_select_low_range_n,
   output logic                      chip_select_high_range_n,
   output logic                      chain_priority_out
);

   ////////////////////////////////////////////////////////////////
   // Strobe edges

   logic fetch_d_ff;
   logic mreq_d_ff;
   logic io_request_strobe_d_ff;
   logic wr_d_ff;
   logic fetch_fall;
   logic fetch_rise;
   logic mreq_fall;
   logic io_request_strobe_fall;
   logic bus_idle;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         fetch_d_ff <= 1'b1;
         mreq_d_ff  <= 1'b1;
         io_request_strobe_d_ff  <= 1'b1;
         wr_d_ff    <= 1'b1;
      end else begin
         fetch_d_ff <= cpu_bus.fetch_cycle_strobe_n;
         mreq_d_ff  <= cpu_bus.mem_request_n;
         io_request_strobe_d_ff  <= cpu_bus.io_request_strobe_n;
         wr_d_ff    <= cpu_bus.wr_n;
      end
   end

   assign fetch_fall = fetch_d_ff & ~cpu_bus.fetch_cycle_strobe_n;
   assign fetch_rise = ~fetch_d_ff & cpu_bus.fetch_cycle_strobe_n;
   assign mreq_fall  = mreq_d_ff & ~cpu_bus.mem_request_n;
   assign io_request_strobe_fall  = io_request_strobe_d_ff & ~cpu_bus.io_request_strobe_n;
   assign bus_idle   = cpu_bus.fetch_cycle_strobe_n & cpu_bus.mem_request_n &
                       cpu_bus.io_request_strobe_n;

   ////////////////////////////////////////////////////////////////
   // Indirect register port

   logic [7:0] ptr_ff;
   logic [7:0] wait_ctrl_ff;
   logic [7:0] mem_bound_ff;
   logic [7:0] cs_bound_ff;
   logic [7:0] misc_ff;
   logic       wait_prog_ff;
   logic [4:0] boot_cnt_ff;
   logic       io_cyc;
   logic       io_wr_ev;
   logic       ptr_wr;
   logic       data_wr;
   logic       port_rd;
   logic       boot_end;

   assign io_cyc   = ~cpu_bus.io_request_strobe_n & cpu_bus.fetch_cycle_strobe_n;
   assign io_wr_ev = io_cyc & wr_d_ff & ~cpu_bus.wr_n;
   assign ptr_wr   = io_wr_ev && cpu_bus.addr[7:0] == swcrc_pkg::PTR_PORT; // see RL18
   assign data_wr  = io_wr_ev && cpu_bus.addr[7:0] == swcrc_pkg::DATA_PORT; // see RL18
   assign port_rd  = io_cyc & ~cpu_bus.rd_n &
                     ((cpu_bus.addr[7:0] == swcrc_pkg::PTR_PORT) ||
                      (cpu_bus.addr[7:0] == swcrc_pkg::DATA_PORT));
   assign boot_end = fetch_rise && boot_cnt_ff == 5'(swcrc_pkg::BOOT_FETCHES - 1);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ptr_ff <= 8'h00;
      end else if (ptr_wr) begin
         ptr_ff <= cpu_bus.data;
      end
   end

   // Fetch count for the boot-time slow timing
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         boot_cnt_ff <= 5'h00;
      end else if (fetch_rise && boot_cnt_ff != 5'(swcrc_pkg::BOOT_FETCHES)) begin
         boot_cnt_ff <= boot_cnt_ff + 5'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wait_ctrl_ff <= swcrc_pkg::WAIT_RST;
         wait_prog_ff <= 1'b0;
      end else if (data_wr && ptr_ff == swcrc_pkg::IDX_WAIT) begin
         wait_ctrl_ff <= cpu_bus.data;
         wait_prog_ff <= 1'b1;
      end else if (boot_end && !wait_prog_ff) begin
         wait_ctrl_ff <= 8'h00;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mem_bound_ff <= swcrc_pkg::MEMB_RST;
      end else if (data_wr && ptr_ff == swcrc_pkg::IDX_MEMB) begin
         mem_bound_ff <= cpu_bus.data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cs_bound_ff <= swcrc_pkg::CSB_RST; // see RL17
      end else if (data_wr && ptr_ff == swcrc_pkg::IDX_CSB) begin
         cs_bound_ff <= cpu_bus.data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         misc_ff <= swcrc_pkg::MISC_RST; // see RL17
      end else if (data_wr && ptr_ff == swcrc_pkg::IDX_MISC) begin
         misc_ff <= cpu_bus.data;
      end
   end

   // Read data, unknown index reads zero
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         data_out <= 8'h00;
         data_oe  <= 1'b0;
      end else begin
         data_oe <= port_rd;
         if (cpu_bus.addr[7:0] == swcrc_pkg::PTR_PORT) begin
            data_out <= ptr_ff;
         end else begin
            unique case (ptr_ff)
               swcrc_pkg::IDX_WAIT: data_out <= wait_ctrl_ff;
               swcrc_pkg::IDX_MEMB: data_out <= mem_bound_ff;
               swcrc_pkg::IDX_CSB:  data_out <= cs_bound_ff;
               swcrc_pkg::IDX_MISC: data_out <= misc_ff;
               default:             data_out <= 8'h00;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Cycle classification and wait counts

   logic [3:0] nib;
   logic       in_range;
   logic [2:0] mem_waits;
   logic [2:0] io_waits;
   logic [2:0] chain_waits;
   logic [2:0] return_from_interrupt_waits;
   logic       long_chain;
   logic       st_fetch;
   logic       st_iack;
   logic       st_io;
   logic       st_mem;
   logic       start;
   logic [2:0] start_n;
   logic       start_return_from_interrupt;
   logic [7:0] op_ff;
   logic       prefix_ff;

   assign nib        = cpu_bus.addr[15:12];
   assign in_range   = (nib >= mem_bound_ff[3:0]) && (nib <= mem_bound_ff[7:4]); // see RL9
   assign mem_waits  = in_range ? {1'b0, wait_ctrl_ff[swcrc_pkg::WC_MEM_HI:swcrc_pkg::WC_MEM_LO]}
                                : 3'h0; // see RL8
   assign io_waits   = swcrc_pkg::onchip_port(cpu_bus.addr[7:0]) ? 3'h0 // see RL12
                     : swcrc_pkg::pair_waits(wait_ctrl_ff[swcrc_pkg::WC_IO_HI:swcrc_pkg::WC_IO_LO]); // see RL11
   assign chain_waits = swcrc_pkg::pair_waits(
                           wait_ctrl_ff[swcrc_pkg::WC_CHAIN_HI:swcrc_pkg::WC_CHAIN_LO]); // see RL14
   assign long_chain = wait_ctrl_ff[swcrc_pkg::WC_CHAIN_HI];

   // Second byte of the return sequence decides its waits
   assign return_from_interrupt_waits = (cpu_bus.data != swcrc_pkg::OPC_RETURN_FROM_INTERRUPT) ? 3'h1
                     : wait_ctrl_ff[swcrc_pkg::WC_CHAIN_LO] ? 3'h4 : 3'h2; // see RL15

   assign st_fetch = fetch_fall & ~cpu_bus.mem_request_n;
   assign st_iack  = fetch_fall & cpu_bus.mem_request_n;
   assign st_io    = io_request_strobe_fall & cpu_bus.fetch_cycle_strobe_n;
   assign st_mem   = mreq_fall & cpu_bus.fetch_cycle_strobe_n;
   assign start    = st_fetch | st_iack | st_io | st_mem;
   assign start_return_from_interrupt = st_fetch & prefix_ff & long_chain; // see RL15

   always_comb begin
      start_n = 3'h0;
      if (st_fetch) begin
         start_n = mem_waits + {2'b00, wait_ctrl_ff[swcrc_pkg::WC_OFE]}; // see RL10
      end else if (st_iack) begin
         start_n = chain_waits;
      end else if (st_io) begin
         start_n = io_waits;
      end else if (st_mem) begin
         start_n = mem_waits;
      end
   end

   // Track the prefix opcode of the return sequence
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         op_ff     <= 8'h00;
         prefix_ff <= 1'b0;
      end else begin
         if (~cpu_bus.fetch_cycle_strobe_n & ~cpu_bus.rd_n) begin
            op_ff <= cpu_bus.data;
         end
         if (fetch_rise) begin
            prefix_ff <= (op_ff == swcrc_pkg::OPC_PREFIX);
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Wait state sequencer

   swcrc_pkg::swcrc_ws_t ws_state_ff;
   swcrc_pkg::swcrc_ws_t nxt_state;
   logic [2:0] ws_cnt_ff;
   logic [2:0] nxt_cnt;
   logic       iack_ff;
   logic       nxt_iack;
   logic       return_from_interrupt_ff;
   logic       nxt_return_from_interrupt;
   logic       trim_ff;
   logic       nxt_trim;
   logic [2:0] return_from_interrupt_left;

   // With no programmed waits the first return wait is the one in which data is seen
   assign return_from_interrupt_left = return_from_interrupt_waits - {2'b00, trim_ff};

   always_comb begin
      nxt_state = ws_state_ff;
      nxt_cnt   = ws_cnt_ff;
      nxt_iack  = iack_ff;
      nxt_return_from_interrupt  = return_from_interrupt_ff;
      nxt_trim  = trim_ff;
      unique case (ws_state_ff)
         swcrc_pkg::WS_IDLE: begin
            if (start) begin
               nxt_iack = st_iack;
               nxt_return_from_interrupt = start_return_from_interrupt;
               nxt_trim = start_return_from_interrupt && start_n == 3'h0;
               if (start_n != 3'h0 || start_return_from_interrupt) begin
                  nxt_state = swcrc_pkg::WS_COUNT;
                  nxt_cnt   = (start_n == 3'h0) ? 3'h1 : start_n;
               end else if (st_iack) begin
                  nxt_state = swcrc_pkg::WS_SETTLE; // see RL14
               end else begin
                  nxt_state = swcrc_pkg::WS_EXT;
               end
            end
         end
         swcrc_pkg::WS_COUNT: begin
            if (ws_cnt_ff > 3'h1) begin
               nxt_cnt = ws_cnt_ff - 3'h1;
            end else if (return_from_interrupt_ff && return_from_interrupt_left != 3'h0) begin
               nxt_cnt  = return_from_interrupt_left; // see RL15
               nxt_return_from_interrupt = 1'b0;
            end else begin
               nxt_return_from_interrupt  = 1'b0;
               nxt_state = iack_ff ? swcrc_pkg::WS_SETTLE : swcrc_pkg::WS_EXT; // see RL7
            end
         end
         swcrc_pkg::WS_SETTLE: begin
            if (io_request_strobe_fall) begin
               nxt_iack = 1'b0;
               if (wait_ctrl_ff[swcrc_pkg::WC_VECT]) begin
                  nxt_state = swcrc_pkg::WS_COUNT; // see RL13
                  nxt_cnt   = 3'h1;
               end else begin
                  nxt_state = swcrc_pkg::WS_EXT;
               end
            end
         end
         swcrc_pkg::WS_EXT: begin
            nxt_state = swcrc_pkg::WS_EXT;
         end
      endcase
      if (bus_idle && ws_state_ff != swcrc_pkg::WS_IDLE) begin
         nxt_state = swcrc_pkg::WS_IDLE;
         nxt_return_from_interrupt  = 1'b0;
         nxt_iack  = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ws_state_ff <= swcrc_pkg::WS_IDLE;
         ws_cnt_ff   <= 3'h0;
         iack_ff     <= 1'b0;
         return_from_interrupt_ff     <= 1'b0;
         trim_ff     <= 1'b0;
      end else begin
         ws_state_ff <= nxt_state;
         ws_cnt_ff   <= nxt_cnt;
         iack_ff     <= nxt_iack;
         return_from_interrupt_ff     <= nxt_return_from_interrupt;
         trim_ff     <= nxt_trim;
      end
   end

   // External wait only heard after the programmed waits
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cpu_wait_n <= 1'b1;
      end else begin
         cpu_wait_n <= (nxt_state != swcrc_pkg::WS_COUNT) &&
                       (nxt_state != swcrc_pkg::WS_EXT || ext_wait_n); // see RL7
      end
   end

   ////////////////////////////////////////////////////////////////
   // Daisy chain, chip selects, reset pin

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         chain_priority_out <= 1'b0;
      end else begin
         chain_priority_out <= chain_priority_in & ~onchip_irq_service; // see RL1
      end
   end

   swcrc_chip_select u_cs (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .nibble    (nib),
      .bound     (cs_bound_ff),
      .en_low    (misc_ff[swcrc_pkg::MC_CS0_EN]),
      .en_high   (misc_ff[swcrc_pkg::MC_CS1_EN]),
      .cs_low_n  (chip_select_low_range_n),
      .cs_high_n (chip_select_high_range_n)
   );

   // Outside source holds reset long enough when output is disabled, see RL6
   swcrc_reset_stretch #(
      .POR_CYCLES (POR_CYCLES),
      .EXT_CYCLES (swcrc_pkg::EXT_RST_CYCLES)
   ) u_rst (
      .ref_clk     (ref_clk),
      .sys_rst     (sys_rst),
      .pin_n       (reset_pin_n_in),
      .out_disable (misc_ff[swcrc_pkg::MC_RST_DIS]),
      .drive_oe    (reset_pin_oe),
      .por_done    ()
   );

   // Open drain: only ever pulls low
   always_ff @(posedge ref_clk) begin
      reset_pin_out <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////
   // Checks

   AST_CHAIN_BLOCK: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RL1
      onchip_irq_service |=> !chain_priority_out) else $error("chain output not blocked");
   AST_EXT_IGNORED: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RL7
      ws_state_ff == swcrc_pkg::WS_COUNT |-> !cpu_wait_n) else $error("wait dropped in count");
   AST_MEM_THREE: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RL8
      st_mem && start_n == 3'h3 && ws_state_ff == swcrc_pkg::WS_IDLE ##1 !bus_idle [*2]
      |-> $past(!cpu_wait_n) && !cpu_wait_n ##1 !cpu_wait_n)
      else $error("three memory waits not given");
   AST_MEM_RANGE: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RL9
      st_mem && !in_range |=> ws_state_ff != swcrc_pkg::WS_COUNT) else $error("wait outside range");
   AST_FETCH_EXTRA: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RL10
      st_fetch && !in_range && !start_return_from_interrupt && wait_ctrl_ff[swcrc_pkg::WC_OFE] && ws_state_ff == swcrc_pkg::WS_IDLE
      |=> ws_state_ff == swcrc_pkg::WS_COUNT && ws_cnt_ff == 3'h1) else $error("fetch extension missing");
   AST_IO_SIX: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RL11
      st_io && ws_state_ff == swcrc_pkg::WS_IDLE && wait_ctrl_ff[1:0] == 2'b11 &&
      !swcrc_pkg::onchip_port(cpu_bus.addr[7:0]) |=> ws_cnt_ff == 3'h6) else $error("six io waits missing");
   AST_IO_ONCHIP: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RL12
      st_io && swcrc_pkg::onchip_port(cpu_bus.addr[7:0]) |=> ws_state_ff != swcrc_pkg::WS_COUNT)
      else $error("wait on on-chip port");
   AST_SETTLE_FREE: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RL14
      ws_state_ff == swcrc_pkg::WS_SETTLE |-> cpu_wait_n) else $error("settle phase held by wait");
   AST_PORT_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RL18
      data_wr && ptr_ff == swcrc_pkg::IDX_MEMB |=> mem_bound_ff == $past(cpu_bus.data))
      else $error("indirect write lost");

endmodule : swcrc_top

/* File: verif/swcrc_pin_model.sv */
/* Reset pin partner: open-drain wire with pull-up and an outside reset source.
   Assumes the device enable is high while it pulls the pin low. */
`timescale 1ns/1ps
module swcrc_pin_model (
   input  wire logic dev_oe,
   input  wire logic ext_pull,
   output logic      pin_n
);
   // Pull-up wins unless some party pulls low
   assign pin_n = !(dev_oe || ext_pull);
endmodule : swcrc_pin_model

/* File: verif/tb_system_wait_cs_reset_ctrl.sv */
/* Bench: register port, wait counts, selects, chain gating, reset pin.
   Assumes 20 MHz clock and a shortened power-on hold. */
`timescale 1ns/1ps
module tb_system_wait_cs_reset_ctrl;
   localparam int POR = 20;
   localparam logic [4:0] IOW = 5'h1a, IOR = 5'h19, FET = 5'h05, IDL = 5'h1f;
   // Entry: address, strobes, waits nibble, {low cs, high cs}
   localparam logic [31:0] TV [9] = '{32'h3000_15_31, 32'h5000_15_02, 32'h9000_15_03, 32'h2000_16_31,
      32'h4000_05_42, 32'h6000_05_12, 32'h0040_1a_61, 32'h0010_19_01, 32'h00f4_1a_01};
   logic [7:0] rst_v [4] = '{swcrc_pkg::WAIT_RST, swcrc_pkg::MEMB_RST, swcrc_pkg::CSB_RST, swcrc_pkg::MISC_RST};
   logic ref_clk = 1'b0, sys_rst = 1'b1, irq_svc = 1'b0, chain_in = 1'b0, ext_pull = 1'b0, ext_w = 1'b1;
   swcrc_pkg::swcrc_bus_t bus = {24'h0, IDL};
   logic pin_n, pin_out, pin_oe, wait_n, doe, csl, csh, cout, cl, ch, oe;
   logic [7:0] dout, rdv;
   int fail_count = 0, samples_checked = 0, n;
   always #25 ref_clk = ~ref_clk;
   swcrc_top #(.POR_CYCLES(POR)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .cpu_bus(bus), .ext_wait_n(ext_w),
      .onchip_irq_service(irq_svc), .chain_priority_in(chain_in), .reset_pin_n_in(pin_n), .reset_pin_out(pin_out),
      .reset_pin_oe(pin_oe), .cpu_wait_n(wait_n), .data_out(dout), .data_oe(doe), .chip_select_low_range_n(csl),
      .chip_select_high_range_n(csh), .chain_priority_out(cout));
   swcrc_pin_model u_pin (.dev_oe(pin_oe), .ext_pull(ext_pull), .pin_n(pin_n));
   ////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk
   // One bus cycle held ten clocks, waits counted
   task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic [4:0] s);
      @(posedge ref_clk) bus <= {a, d, s};
      n = 0;
      repeat (10) begin
         @(posedge ref_clk);
         #1 n += int'(wait_n !== 1'b1);
      end
      rdv = dout;
      oe = doe;
      cl = csl;
      ch = csh;
      @(posedge ref_clk) bus <= {a, d, IDL};
   endtask : cyc
   task automatic wreg(input logic [7:0] i, input logic [7:0] v);
      cyc({8'h00, swcrc_pkg::PTR_PORT}, i, IOW);
      cyc({8'h00, swcrc_pkg::DATA_PORT}, v, IOW);
   endtask : wreg
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      #1 chk("por_hold", 8'(pin_oe), 8'h01);
      repeat (POR + 5) @(posedge ref_clk);
      #1 chk("por_end", 8'({pin_oe, pin_n}), 8'h01);
      chk("pin_out", 8'(pin_out), 8'h00);
      for (int i = 0; i < 4; i++) begin
         wreg(swcrc_pkg::PTR_PORT, 8'h00);
         cyc({8'h00, swcrc_pkg::PTR_PORT}, 8'(i), IOW);
         cyc({8'h00, swcrc_pkg::DATA_PORT}, 8'h00, IOR);
         chk("reg_rst", rdv, rst_v[i]);
         chk("data_oe", 8'(oe), 8'h01);
      end
      cyc(16'hf000, 8'h00, IDL);
      chk("cs_boot", 8'({cl, ch}), 8'h01);
      chk("data_oe_idle", 8'(oe), 8'h00);
      $display("test registers done");
      wreg(swcrc_pkg::IDX_MEMB, 8'h42);
      wreg(swcrc_pkg::IDX_CSB, 8'h83);
      wreg(swcrc_pkg::IDX_MISC, 8'h03);
      wreg(swcrc_pkg::IDX_WAIT, 8'h1f);
      for (int i = 0; i < 9; i++) begin
         cyc(TV[i][31:16], 8'h00, TV[i][12:8]);
         chk("waits", 8'(n), 8'(TV[i][7:4]));
         chk("cs", 8'({cl, ch}), 8'(TV[i][1:0]));
      end
      for (int c = 2; c < 4; c++) begin
         wreg(swcrc_pkg::IDX_WAIT, 8'(c << 6));
         cyc(16'h0100, swcrc_pkg::OPC_PREFIX, FET);
         cyc(16'h0101, swcrc_pkg::OPC_RETURN_FROM_INTERRUPT, FET);
         chk("return_from_interrupt", 8'(n), 8'(2 * c - 2));
         cyc(16'h0102, swcrc_pkg::OPC_PREFIX, FET);
         cyc(16'h0103, 8'h00, FET);
         chk("return_from_interrupt_other", 8'(n), 8'h01);
         ext_w <= 1'b0;
         cyc(16'h0000, 8'h00, 5'h0f);
         ext_w <= 1'b1;
         chk("iack", 8'(n), 8'(2 * c));
      end
      wreg(swcrc_pkg::IDX_WAIT, 8'h20);
      @(posedge ref_clk) bus <= {24'h0, 5'h0f};
      repeat (3) @(posedge ref_clk);
      bus <= {24'h0, 5'h0b};
      n = 0;
      repeat (4) begin
         @(posedge ref_clk);
         #1 n += int'(wait_n !== 1'b1);
      end
      chk("vector", 8'(n), 8'h01);
      @(posedge ref_clk) bus <= {24'h0, IDL};
      $display("test waits done");
      for (int k = 0; k < 4; k++) begin
         @(posedge ref_clk) {chain_in, irq_svc} <= 2'(k);
         repeat (3) @(posedge ref_clk);
         #1 chk("chain", 8'(cout), 8'(k == 2));
      end
      for (int d = 0; d < 2; d++) begin
         wreg(swcrc_pkg::IDX_MISC, {5'h00, 1'(d), 2'b11});
         @(posedge ref_clk) ext_pull <= 1'b1;
         n = 0;
         for (int t = 0; t < 30; t++) begin
            @(posedge ref_clk);
            if (t == 2) ext_pull <= 1'b0;
            #1 n += int'(pin_oe !== 1'b0);
         end
         chk("rst_out", 8'(n), d ? 8'h00 : 8'h10);
      end
      $display("test reset pin done");
      finish_test();
   end
endmodule : tb_system_wait_cs_reset_ctrl
